// file: bench/mdr_cpu_model.sv
// cpu-side model driving the special function register port
`timescale 1ns/1ps
`default_nettype none
module mdr_cpu_model (
  // clock
  input  wire logic       clk_i,
  // register port
  output logic [7:0]      sfr_addr_o,
  output logic            sfr_wr_o,
  output logic            sfr_rd_o,
  output logic [7:0]      sfr_wdata_o,
  input  wire logic [7:0] sfr_rdata_i
);
  // idle bus, strobes low
  initial begin
    sfr_addr_o  = 8'h00;
    sfr_wr_o    = 1'b0;
    sfr_rd_o    = 1'b0;
    sfr_wdata_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one byte per strobe; data inverted after release so stale values never match
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_o  = a;
    sfr_wdata_o = d;
    sfr_wr_o    = 1'b1;
    @(negedge clk_i);
    sfr_wr_o    = 1'b0;
    sfr_wdata_o = ~d;
  endtask

  // read data taken one cycle after the strobe; writes to status never relied on
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_o = a;
    sfr_rd_o   = 1'b1;
    @(negedge clk_i);
    d        = sfr_rdata_i;
    sfr_rd_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// self-checking bench for the decoder host register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                  clk_i = 1'b0;
  logic                  rstn_i = 1'b0;
  logic [7:0]            sfr_addr, sfr_wdata, sfr_rdata, d;
  logic                  sfr_wr, sfr_rd, irq_en = 1'b1, gie = 1'b1, irq;
  mdr_pkg::mdr_dec_evt_t evt = '0;
  mdr_pkg::mdr_dec_ctl_t ctl;
  logic                  s_valid, s_ready = 1'b0, s_full;
  mdr_pkg::mdr_word_t    s_word;
  logic [7:0]            q[$];
  int                    err_total = 0;
  int                    num_checks = 0;
  int                    cyc = 0;

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  mdr_cpu_model u_cpu (.clk_i(clk_i), .sfr_addr_o(sfr_addr), .sfr_wr_o(sfr_wr),
    .sfr_rd_o(sfr_rd), .sfr_wdata_o(sfr_wdata), .sfr_rdata_i(sfr_rdata));

  mdr_regs #(.BUF_DEPTH(2)) DUT (.clk_i(clk_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr),
    .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd), .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata),
    .decoder_irq_enable_i(irq_en), .global_irq_enable_i(gie), .decoder_irq_o(irq),
    .dec_evt_i(evt), .dec_ctl_o(ctl), .stream_valid_o(s_valid), .stream_ready_i(s_ready),
    .stream_word_o(s_word), .stream_full_o(s_full));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // one-cycle event pulse on the datapath side, level fields kept
  task automatic pulse(input int b);
    @(negedge clk_i);
    evt[b] = 1'b1;
    @(negedge clk_i);
    evt = mdr_pkg::mdr_dec_evt_t'(evt & 10'h00f);
  endtask

  // hang guard, far above the expected run length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    u_cpu.sfr_read(mdr_pkg::CTRL_ADDR, d);
    chk("ctrl reset", 8'h3f, d);
    chk("ctl out", 8'h01, {5'h00, ctl});
    u_cpu.sfr_read(mdr_pkg::STAT_ADDR, d);
    chk("stat reset", 8'h01, d);
  endtask

  task automatic t_ctrl();
    u_cpu.sfr_write(mdr_pkg::CTRL_ADDR, 8'h40);
    chk("boost on", 8'h02, {5'h00, ctl});
    u_cpu.sfr_write(mdr_pkg::CTRL_ADDR, 8'ha0);
    chk("enable crc", 8'h05, {5'h00, ctl});
    u_cpu.sfr_read(mdr_pkg::CTRL_ADDR, d);
    chk("ctrl rd", 8'ha0, d);
    u_cpu.sfr_write(mdr_pkg::STAT_ADDR, 8'hfe);
    u_cpu.sfr_read(mdr_pkg::STAT_ADDR, d);
    chk("stat ro", 8'h01, d & 8'hbf);
    u_cpu.sfr_read(8'h55, d);
    chk("unmapped", 8'h00, d);
  endtask

  // each error flag, unmasked then masked, and read clearing
  task automatic t_errors();
    for (int i = 0; i < 3; i++) begin
      u_cpu.sfr_write(mdr_pkg::CTRL_ADDR, 8'h9f & ~(8'h04 >> i));
      u_cpu.sfr_read(mdr_pkg::STAT_ADDR, d);
      pulse(7 - i);
      @(negedge clk_i);
      chk("irq unmasked", 8'h01, {7'h00, irq});
      // one pass drops the decoder enable, the others the global enable
      gie    = (i == 1);
      irq_en = (i != 1);
      repeat (2) @(negedge clk_i);
      chk("irq gated", 8'h00, {7'h00, irq});
      gie    = 1'b1;
      irq_en = 1'b1;
      u_cpu.sfr_read(mdr_pkg::STAT_ADDR, d);
      chk("err set", 8'h01, {7'h00, d[5 - i]});
      u_cpu.sfr_read(mdr_pkg::STAT_ADDR, d);
      chk("err clr", 8'h00, {7'h00, d[5 - i]});
      chk("irq clr", 8'h00, {7'h00, irq});
      u_cpu.sfr_write(mdr_pkg::CTRL_ADDR, 8'h9f);
      pulse(7 - i);
      repeat (2) @(negedge clk_i);
      chk("irq masked", 8'h00, {7'h00, irq});
      u_cpu.sfr_read(mdr_pkg::STAT_ADDR, d);
      chk("masked set", 8'h01, {7'h00, d[5 - i]});
    end
  endtask

  // flag set in the very cycle of a clearing read survives
  task automatic t_race();
    fork
      u_cpu.sfr_read(mdr_pkg::STAT_ADDR, d);
      pulse(5);
    join
    u_cpu.sfr_read(mdr_pkg::STAT_ADDR, d);
    chk("set wins", 8'h01, {7'h00, d[3]});
  endtask

  task automatic t_header();
    evt.sample_rate_code = mdr_pkg::FS_32_16;
    evt.version_one = 1'b0;
    pulse(4);
    u_cpu.sfr_read(mdr_pkg::STAT_ADDR, d);
    chk("fs v2", 8'h04, d & 8'h07);
    evt.sample_rate_code = mdr_pkg::FS_48_24;
    evt.version_one = 1'b1;
    pulse(4);
    u_cpu.sfr_read(mdr_pkg::STAT_ADDR, d);
    chk("fs v1", 8'h03, d & 8'h07);
  endtask

  task automatic t_anc();
    u_cpu.sfr_write(mdr_pkg::CTRL_ADDR, 8'h8f);
    evt.aux_nonempty = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("irq anc", 8'h01, {7'h00, irq});
    u_cpu.sfr_read(mdr_pkg::STAT_ADDR, d);
    u_cpu.sfr_read(mdr_pkg::STAT_ADDR, d);
    chk("anc held", 8'h01, {7'h00, d[7]});
    evt.aux_nonempty = 1'b0;
    repeat (3) @(negedge clk_i);
    u_cpu.sfr_read(mdr_pkg::STAT_ADDR, d);
    chk("anc clr", 8'h00, {7'h00, d[7]});
  endtask

  // request, stream writes against a stalled receiver, then drain in order
  task automatic t_stream();
    u_cpu.sfr_write(mdr_pkg::CTRL_ADDR, 8'h97);
    pulse(9);
    // interrupt is registered one cycle behind the flag
    @(negedge clk_i);
    chk("irq req", 8'h01, {7'h00, irq});
    u_cpu.sfr_read(mdr_pkg::AUX_ADDR, d);
    chk("aux req", 8'h18, d & 8'h18);
    u_cpu.sfr_read(mdr_pkg::STAT_ADDR, d);
    chk("req flag", 8'h01, {7'h00, d[6]});
    u_cpu.sfr_write(mdr_pkg::STREAM_ADDR, 8'ha5);
    u_cpu.sfr_write(mdr_pkg::STREAM_ADDR, 8'h5a);
    u_cpu.sfr_write(mdr_pkg::STREAM_ADDR, 8'h3c);
    chk("full", 8'h01, {7'h00, s_full});
    u_cpu.sfr_read(mdr_pkg::AUX_ADDR, d);
    chk("breq clr", 8'h00, d & 8'h08);
    // frame done while the initial fill is still open keeps the frame request
    pulse(8);
    u_cpu.sfr_read(mdr_pkg::AUX_ADDR, d);
    chk("freq held", 8'h10, d & 8'h10);
    s_ready = 1'b1;
    // settled values before the edge that takes the word
    repeat (6) begin
      @(negedge clk_i);
      if (s_valid === 1'b1 && s_ready === 1'b1) q.push_back(s_word.stream_byte);
    end
    @(negedge clk_i);
    s_ready = 1'b0;
    chk("count", 8'h02, 8'(q.size()));
    chk("word0", 8'ha5, q[0]);
    chk("word1", 8'h5a, q[1]);
    chk("not full", 8'h00, {7'h00, s_full});
    u_cpu.sfr_write(mdr_pkg::CTRL_ADDR, 8'h17);
    chk("ctl off", 8'h00, {5'h00, ctl});
    u_cpu.sfr_read(mdr_pkg::AUX_ADDR, d);
    chk("aux off", 8'h00, d & 8'h18);
  endtask

  // reset asserted mid-run brings both registers back
  task automatic t_rst_mid();
    @(negedge clk_i);
    rstn_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("irq in reset", 8'h00, {7'h00, irq});
    rstn_i = 1'b1;
    u_cpu.sfr_read(mdr_pkg::CTRL_ADDR, d);
    chk("ctrl rerst", 8'h3f, d);
    u_cpu.sfr_read(mdr_pkg::STAT_ADDR, d);
    chk("stat rerst", 8'h01, d);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(negedge clk_i);
    rstn_i = 1'b1;
    t_reset();
    t_ctrl();
    t_errors();
    t_race();
    t_header();
    t_anc();
    t_stream();
    t_rst_mid();
    give_verdict();
  end
endmodule
`default_nettype wire

// file: src/mdr_pkg.sv
// package for the audio decoder host register bank
package mdr_pkg;

  // register addresses on the cpu special function register port
  localparam logic [7:0] CTRL_ADDR   = 8'haa;
  localparam logic [7:0] STREAM_ADDR = 8'hac;
  localparam logic [7:0] AUX_ADDR    = 8'haf;
  localparam logic [7:0] STAT_ADDR   = 8'hc8;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h3f;
  localparam logic [7:0] STAT_RESET = 8'h01;

  // control bit positions
  localparam int CTRL_EN_BIT    = 7;
  localparam int CTRL_BOOST_BIT = 6;
  localparam int CTRL_CRCP_BIT  = 5;
  localparam int CTRL_MANC_BIT  = 4;
  localparam int CTRL_MREQ_BIT  = 3;
  localparam int CTRL_MLAY_BIT  = 2;
  localparam int CTRL_MSYN_BIT  = 1;
  localparam int CTRL_MCRC_BIT  = 0;

  // status bit positions
  localparam int STAT_ANC_BIT = 7;
  localparam int STAT_REQ_BIT = 6;
  localparam int STAT_LAY_BIT = 5;
  localparam int STAT_SYN_BIT = 4;
  localparam int STAT_CRC_BIT = 3;
  localparam int STAT_FS_LSB  = 1;
  localparam int STAT_VER_BIT = 0;

  // auxiliary status bit positions
  localparam int AUX_FREQ_BIT = 4;
  localparam int AUX_BREQ_BIT = 3;

  // sample rate codes (meaning depends on version bit)
  localparam logic [1:0] FS_441_2205 = 2'h0;
  localparam logic [1:0] FS_48_24    = 2'h1;
  localparam logic [1:0] FS_32_16    = 2'h2;
  localparam logic [1:0] FS_RESERVED = 2'h3;

  // bytes asked for by the first request after enable
  localparam int FIRST_FILL_BYTES = 1024;

  // events reported by the decoding datapath
  typedef struct packed {
    logic       byte_request;
    logic       frame_done;
    logic       layer_error;
    logic       sync_error;
    logic       crc_error;
    logic       header_valid;
    logic [1:0] sample_rate_code;
    logic       version_one;
    logic       aux_nonempty;
  } mdr_dec_evt_t;

  // controls driven towards the datapath
  typedef struct packed {
    logic decoder_enable;
    logic bass_boost_enable;
    logic crc_error_play_enable;
  } mdr_dec_ctl_t;

  // stream byte towards the datapath
  typedef struct packed {
    logic [7:0] stream_byte;
  } mdr_word_t;

endpackage

// file: src/mdr_regs.sv
// host register bank of the audio layer 3 decoder
//
// Summary of operation
// - control bit 6 switches bass boost
// - control bit 5 plays crc-error frames
// - bits 4,3 mask ancillary and request interrupts
// - bits 2,1,0 mask layer/sync/crc error interrupts
// - control resets to 0x3f
// - ancillary flag follows buffer non-empty
// - request flag set by decoder, read clears
// - layer error flag set, read clears
// - sync error flag set, read clears
// - crc error flag set, read clears
// - bits 2-1 give header sample-rate code
// - bit 0 shows version one frame
// - status resets to 0x01
// - status is read-only, writes ignored
// - stream byte writes feed input buffer
// - rate code meaning depends on version
// - stream writes acknowledge; first request 1024 bytes
// - frame request holds, byte request cleared per write
// - unmasked set flag raises gated interrupt
`timescale 1ns/1ps
`default_nettype none
module mdr_regs #(
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  // special function register port
  input  wire logic [7:0]          sfr_addr_i,
  input  wire logic                sfr_wr_i,
  input  wire logic                sfr_rd_i,
  input  wire logic [7:0]          sfr_wdata_i,
  output logic [7:0]               sfr_rdata_o,
  // cpu interrupt enables
  input  wire logic                decoder_irq_enable_i,
  input  wire logic                global_irq_enable_i,
  output logic                     decoder_irq_o,
  // decoding datapath
  input  wire mdr_pkg::mdr_dec_evt_t dec_evt_i,
  output mdr_pkg::mdr_dec_ctl_t    dec_ctl_o,
  output logic                     stream_valid_o,
  input  wire logic                stream_ready_i,
  output mdr_pkg::mdr_word_t       stream_word_o,
  output logic                     stream_full_o
);

  //////////////////////////////////////////////////////////////////////////
  // access decode
  logic wr_ctrl, wr_stream, rd_stat;
  assign wr_ctrl   = sfr_wr_i && (sfr_addr_i == mdr_pkg::CTRL_ADDR);
  assign wr_stream = sfr_wr_i && (sfr_addr_i == mdr_pkg::STREAM_ADDR);
  assign rd_stat   = sfr_rd_i && (sfr_addr_i == mdr_pkg::STAT_ADDR);

  //////////////////////////////////////////////////////////////////////////
  // control register
  logic [7:0] ctrl_q, ctrl_d;

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = sfr_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= mdr_pkg::CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  logic dec_en;
  assign dec_en = ctrl_q[mdr_pkg::CTRL_EN_BIT];

  //////////////////////////////////////////////////////////////////////////
  // status flags: set beats read-clear
  logic anc_q, anc_d, req_q, req_d, lay_q, lay_d, syn_q, syn_d, crc_q, crc_d;
  logic [1:0] fs_q, fs_d;
  logic       ver_q, ver_d;

  always_comb begin
    anc_d = dec_evt_i.aux_nonempty;
    req_d = (dec_en && dec_evt_i.byte_request) || (req_q && !rd_stat);
    lay_d = (dec_en && dec_evt_i.layer_error) || (lay_q && !rd_stat);
    syn_d = (dec_en && dec_evt_i.sync_error) || (syn_q && !rd_stat);
    crc_d = (dec_en && dec_evt_i.crc_error) || (crc_q && !rd_stat);
    fs_d  = fs_q;
    ver_d = ver_q;
    // header fields only move on a decoded header
    if (dec_evt_i.header_valid) begin
      fs_d  = dec_evt_i.sample_rate_code;
      ver_d = dec_evt_i.version_one;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      anc_q <= 1'b0;
      req_q <= 1'b0;
      lay_q <= 1'b0;
      syn_q <= 1'b0;
      crc_q <= 1'b0;
      fs_q  <= mdr_pkg::STAT_RESET[2:1];
      ver_q <= mdr_pkg::STAT_RESET[0];
    end else begin
      anc_q <= anc_d;
      req_q <= req_d;
      lay_q <= lay_d;
      syn_q <= syn_d;
      crc_q <= crc_d;
      fs_q  <= fs_d;
      ver_q <= ver_d;
    end
  end

  logic [7:0] stat_v;
  // status writes have no decode, so they change nothing
  assign stat_v = {anc_q, req_q, lay_q, syn_q, crc_q, fs_q, ver_q};

  //////////////////////////////////////////////////////////////////////////
  // request handshake: frame request holds, byte request per write
  logic freq_q, freq_d, breq_q, breq_d;
  logic [10:0] fill_q, fill_d;
  logic        first_q, first_d;

  always_comb begin
    freq_d  = freq_q;
    breq_d  = breq_q;
    fill_d  = fill_q;
    first_d = first_q;
    if (!dec_en) begin
      // disabling stops requests and rearms the initial fill
      freq_d  = 1'b0;
      breq_d  = 1'b0;
      first_d = 1'b1;
      fill_d  = '0;
    end else begin
      if (dec_evt_i.byte_request) begin
        freq_d = 1'b1;
        breq_d = 1'b1;
        if (first_q) begin
          fill_d  = 11'(mdr_pkg::FIRST_FILL_BYTES);
          first_d = 1'b0;
        end
      end
      if (wr_stream) begin
        breq_d = 1'b0;
        if (fill_q != '0) begin
          fill_d = fill_q - 11'h1;
        end
      end
      // frame request drops on frame done once the fill count is done
      if (dec_evt_i.frame_done && (fill_d == '0)) begin
        freq_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      freq_q  <= 1'b0;
      breq_q  <= 1'b0;
      fill_q  <= '0;
      first_q <= 1'b1;
    end else begin
      freq_q  <= freq_d;
      breq_q  <= breq_d;
      fill_q  <= fill_d;
      first_q <= first_d;
    end
  end

  logic [7:0] aux_v;
  always_comb begin
    aux_v = 8'h00;
    aux_v[mdr_pkg::AUX_FREQ_BIT] = freq_q;
    aux_v[mdr_pkg::AUX_BREQ_BIT] = breq_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // read data register
  logic [7:0] rdata_q, rdata_d;
  always_comb begin
    case (sfr_addr_i)
      mdr_pkg::CTRL_ADDR: rdata_d = ctrl_q;
      mdr_pkg::STAT_ADDR: rdata_d = stat_v;
      mdr_pkg::AUX_ADDR:  rdata_d = aux_v;
      default:            rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign sfr_rdata_o = rdata_q;

  //////////////////////////////////////////////////////////////////////////
  // interrupt and datapath controls, all registered
  logic irq_q, irq_d;
  mdr_pkg::mdr_dec_ctl_t ctl_q, ctl_d;
  always_comb begin
    irq_d = ((anc_q && !ctrl_q[mdr_pkg::CTRL_MANC_BIT])
          || (req_q && !ctrl_q[mdr_pkg::CTRL_MREQ_BIT])
          || (lay_q && !ctrl_q[mdr_pkg::CTRL_MLAY_BIT])
          || (syn_q && !ctrl_q[mdr_pkg::CTRL_MSYN_BIT])
          || (crc_q && !ctrl_q[mdr_pkg::CTRL_MCRC_BIT]))
          && decoder_irq_enable_i && global_irq_enable_i;
    ctl_d.decoder_enable        = ctrl_d[mdr_pkg::CTRL_EN_BIT];
    ctl_d.bass_boost_enable     = ctrl_d[mdr_pkg::CTRL_BOOST_BIT];
    ctl_d.crc_error_play_enable = ctrl_d[mdr_pkg::CTRL_CRCP_BIT];
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_q <= 1'b0;
      ctl_q <= '{decoder_enable: 1'b0, bass_boost_enable: 1'b0,
                 crc_error_play_enable: 1'b0};
    end else begin
      irq_q <= irq_d;
      ctl_q <= ctl_d;
    end
  end
  assign decoder_irq_o = irq_q;
  assign dec_ctl_o     = ctl_q;

  //////////////////////////////////////////////////////////////////////////
  // stream byte path through a two-entry buffer; full goes to the datapath on stream_full_o
  logic       buf_ready, buf_valid;
  logic [7:0] buf_data;
  mdr_skid_buf #(
    .WIDTH (8),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (wr_stream),
    .in_ready_o  (buf_ready),
    .in_data_i   (sfr_wdata_i),
    .out_valid_o (buf_valid),
    .out_ready_i (stream_ready_i && !(stream_valid_o)),
    .out_data_o  (buf_data)
  );

  // output stage register so the datapath sees flops only
  logic       sv_q, sv_d, full_q;
  logic [7:0] sd_q, sd_d;
  always_comb begin
    sv_d = sv_q;
    sd_d = sd_q;
    if (sv_q && stream_ready_i) begin
      sv_d = 1'b0;
    end
    if (!sv_q && buf_valid && stream_ready_i) begin
      sv_d = 1'b1;
      sd_d = buf_data;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sv_q   <= 1'b0;
      sd_q   <= 8'h00;
      full_q <= 1'b0;
    end else begin
      sv_q   <= sv_d;
      sd_q   <= sd_d;
      full_q <= !buf_ready;
    end
  end
  assign stream_valid_o            = sv_q;
  assign stream_word_o.stream_byte = sd_q;
  assign stream_full_o             = full_q;

  //////////////////////////////////////////////////////////////////////////
  // checks
  a_ctrl_reset: assert property (@(posedge clk_i) $rose(rstn_i) |-> ctrl_q == 8'h3f)
    else $error("control not at reset value");
  a_req_set_wins: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (dec_en && dec_evt_i.byte_request) |=> req_q)
    else $error("request flag lost");
  a_flag_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (rd_stat && !dec_evt_i.layer_error) |=> !lay_q)
    else $error("layer flag not cleared");
  a_anc_follow: assert property (@(posedge clk_i) disable iff (!rstn_i)
    1'b1 |=> anc_q == $past(dec_evt_i.aux_nonempty))
    else $error("ancillary flag mismatch");
  a_breq_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (wr_stream && !dec_evt_i.byte_request) |=> !breq_q)
    else $error("byte request not cleared");
  a_irq_masked: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ctrl_q[4:0] == 5'h1f) |=> !decoder_irq_o)
    else $error("masked interrupt raised");
  a_disable_req: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !dec_en |=> !freq_q && !breq_q)
    else $error("request while disabled");
  a_ctrl_boost: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_ctrl |=> dec_ctl_o.bass_boost_enable == $past(sfr_wdata_i[6]))
    else $error("boost not following control");
endmodule
`default_nettype wire

// file: src/mdr_skid_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module mdr_skid_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // pointer and storage update; full refuses pushes so nothing is overwritten
  always_comb begin
    push  = in_valid_i && in_ready_o;
    pop   = (cnt_q != '0) && out_ready_i;
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data_i;
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
endmodule
`default_nettype wire
